//--- gear_mode_pkg.sv
// Shared constants for the gear ratio and control mode switch block.
// Assumes a single 20 MHz drive clock and synchronous active-low reset.
package gear_mode_pkg;
  // ----------------------------------------------------------------------
  // Register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_NUM_PRIMARY = 8'h00;
  localparam logic [7:0] ADDR_NUM_TWO = 8'h04;
  localparam logic [7:0] ADDR_NUM_THREE = 8'h08;
  localparam logic [7:0] ADDR_NUM_FOUR = 8'h0c;
  localparam logic [7:0] ADDR_DENOM = 8'h10;
  localparam logic [7:0] ADDR_MODE_SET = 8'h14;
  localparam logic [7:0] ADDR_TUNE_MODE = 8'h18;
  localparam logic [7:0] ADDR_TUNE_LEVEL = 8'h1c;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  localparam logic [7:0] ADDR_TARGET = 8'h24;
  // ----------------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------------
  localparam int GEAR_W = 27;
  localparam logic [26:0] GEAR_MAX = 27'h4000000;
  localparam logic [26:0] NUM_RESET = 27'h0000001;
  localparam logic [26:0] DEN_RESET = 27'h0000001;
  localparam logic [31:0] ENCODER_PPR = 32'h00400000;
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [15:0] TUNE_MODE_MAX = 16'h0004;
  localparam logic [15:0] TUNE_MODE_RESET = 16'h0002;
  localparam logic [5:0] TUNE_LEVEL_MIN = 6'h01;
  localparam logic [5:0] TUNE_LEVEL_MAX = 6'h20;
  localparam logic [5:0] TUNE_LEVEL_RESET = 6'h0a;
  // ----------------------------------------------------------------------
  // Control mode codes
  // ----------------------------------------------------------------------
  localparam logic [15:0] MODE_PT_S = 16'h1001;
  localparam logic [15:0] MODE_PT_T = 16'h1005;
  localparam logic [15:0] MODE_PR_S = 16'h1011;
  localparam logic [15:0] MODE_PR_T = 16'h1015;
  localparam logic [15:0] MODE_S_T = 16'h1003;
  localparam logic [15:0] MODE_PT_PR = 16'h1020;
  // Active loop encoding
  localparam logic [1:0] LOOP_POS = 2'h0;
  localparam logic [1:0] LOOP_SPEED = 2'h1;
  localparam logic [1:0] LOOP_TORQUE = 2'h2;
  // Status bit positions
  localparam int ST_LOOP_LSB = 0;
  localparam int ST_INTERNAL = 2;
  localparam int ST_GEAR_LSB = 3;
  localparam int ST_PENDING = 5;
  localparam int ST_STAGED_DIFF = 6;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : gear_mode_pkg

//--- gear_ratio_and_mode_switch.sv
// Gear ratio scaling of position pulses and hybrid control-mode switching.
// Assumes an AXI4-Lite master on aclk and raw dry-contact inputs from pins.
// Operation
// R01: Two select inputs pick one of four gear numerators.
// R02: Controller keeps gear ratio between one fiftieth and 64000.
// R03: Numerators and denominator hold up to two to the 26; numerator two is 1.
// R04: Controller changes gear settings only with servo off.
// R05: Encoder resolution is 4194304 counts per revolution.
// R06: Each pulse adds numerator over denominator counts, remainder carried.
// R07: Mode codes 1001h, 1005h, 1011h select position-speed/torque hybrids.
// R08: Codes 1015h, 1003h, 1020h select further hybrids and source switch.
// R09: Position/speed: off position, on speed; source: off external, on internal.
// R10: Speed/torque: off speed, on torque; torque/position: off torque, on pos.
// R11: Controller enables the mode switch input before hybrid switching.
// R12: Position/speed change happens only when zero speed is detected.
// R13: Torque/position change happens only when zero speed is detected.
// R14: Controller drives position trigger on entering internal position mode.
// R15: Shared input is forward start in speed, reverse select in torque.
// R16: Paired inputs remap to the new mode's function on a mode change.
// R17: Crosswise pairing reverses direction between speed and torque.
// R18: Controller should change mode only with motor stopped.
// R19: Tuning mode accepts 0 to 4, resets to 2.
// R20: Tuning response level accepts 1 to 32, resets to 10.
// R21: Mode setting takes effect only after a restart.
// R22: Inputs are synchronised; shorted is one, open is zero.
`timescale 1ns/1ps
module gear_ratio_and_mode_switch #(
  parameter int GEAR_W = 27
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic gear_select_low,
  input wire logic gear_select_high,
  input wire logic mode_switch_input,
  input wire logic shared_start_pin,
  input wire logic zero_speed,
  input wire logic cmd_pulse,
  input wire logic cmd_dir,
  output logic [1:0] active_loop,
  output logic internal_source,
  output logic forward_start_input,
  output logic reverse_select_input,
  output logic target_step,
  output logic [31:0] target_pos
);
  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [3:0] pin_raw;
  logic [3:0] s1_q, s2_q, s3_q, pin_q;
  assign pin_raw = {shared_start_pin, mode_switch_input, gear_select_high,
                    gear_select_low};
  // A shorted contact reads one; change counted once stages two and three agree
  for (genvar i = 0; i < 4; i++) begin : g_sync
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        s1_q[i] <= 1'b0;
        s2_q[i] <= 1'b0;
        s3_q[i] <= 1'b0;
        pin_q[i] <= 1'b0;
      end else begin
        s1_q[i] <= pin_raw[i]; // R22
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
        if (s2_q[i] == s3_q[i]) begin
          pin_q[i] <= s3_q[i]; // R22
        end
      end
    end
  end
  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  logic [GEAR_W-1:0] num_q [4];
  logic [GEAR_W-1:0] den_q;
  // Retained setting: aresetn leaves it, so it goes live at the next restart
  logic [15:0] mode_live_q, mode_staged_q = gear_mode_pkg::MODE_RESET;
  logic [15:0] tune_mode_q;
  logic [5:0] tune_level_q;
  logic aw_hold_q, w_hold_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic wr_fire;
  logic wr_ok;
  // Address and data are latched independently so they may come in any order
  assign awready = !aw_hold_q && !bvalid;
  assign wready = !w_hold_q && !bvalid;
  assign wr_fire = aw_hold_q && w_hold_q && !bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h00000000;
    end else begin
      if (awvalid && awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= awaddr;
      end else if (wr_fire) begin
        aw_hold_q <= 1'b0;
      end
      if (wvalid && wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= wdata;
      end else if (wr_fire) begin
        w_hold_q <= 1'b0;
      end
    end
  end
  // Out-of-range values are refused whole with SLVERR, keeping the old value
  always_comb begin
    wr_ok = 1'b1;
    unique case (aw_addr_q)
      gear_mode_pkg::ADDR_NUM_PRIMARY, gear_mode_pkg::ADDR_NUM_TWO,
      gear_mode_pkg::ADDR_NUM_THREE, gear_mode_pkg::ADDR_NUM_FOUR,
      gear_mode_pkg::ADDR_DENOM:
        wr_ok = (w_data_q[31:0] != 32'h0) &&
                (w_data_q <= {5'h00, gear_mode_pkg::GEAR_MAX}); // R03
      gear_mode_pkg::ADDR_MODE_SET: wr_ok = 1'b1;
      gear_mode_pkg::ADDR_TUNE_MODE:
        wr_ok = w_data_q <= {16'h0000, gear_mode_pkg::TUNE_MODE_MAX}; // R19
      gear_mode_pkg::ADDR_TUNE_LEVEL:
        wr_ok = (w_data_q >= {26'h0, gear_mode_pkg::TUNE_LEVEL_MIN}) &&
                (w_data_q <= {26'h0, gear_mode_pkg::TUNE_LEVEL_MAX}); // R20
      default: wr_ok = 1'b0;
    endcase
  end
  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= gear_mode_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp <= wr_ok ? gear_mode_pkg::RESP_OKAY : gear_mode_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end
  // Settings storage; wstrb ignored since every setting is a whole value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int k = 0; k < 4; k++) begin
        num_q[k] <= GEAR_W'(gear_mode_pkg::NUM_RESET); // R03
      end
      den_q <= GEAR_W'(gear_mode_pkg::DEN_RESET);
      tune_mode_q <= gear_mode_pkg::TUNE_MODE_RESET; // R19
      tune_level_q <= gear_mode_pkg::TUNE_LEVEL_RESET; // R20
    end else if (wr_fire && wr_ok) begin
      unique case (aw_addr_q)
        gear_mode_pkg::ADDR_NUM_PRIMARY: num_q[0] <= w_data_q[GEAR_W-1:0];
        gear_mode_pkg::ADDR_NUM_TWO: num_q[1] <= w_data_q[GEAR_W-1:0];
        gear_mode_pkg::ADDR_NUM_THREE: num_q[2] <= w_data_q[GEAR_W-1:0];
        gear_mode_pkg::ADDR_NUM_FOUR: num_q[3] <= w_data_q[GEAR_W-1:0];
        gear_mode_pkg::ADDR_DENOM: den_q <= w_data_q[GEAR_W-1:0];
        gear_mode_pkg::ADDR_MODE_SET: mode_staged_q <= w_data_q[15:0];
        gear_mode_pkg::ADDR_TUNE_MODE: tune_mode_q <= w_data_q[15:0];
        gear_mode_pkg::ADDR_TUNE_LEVEL: tune_level_q <= w_data_q[5:0];
        default: ;
      endcase
    end
  end
  // Live mode only follows the staged value across a reset, as on power-up
  logic mode_load_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_live_q <= gear_mode_pkg::MODE_RESET;
    end else if (mode_load_q) begin
      mode_live_q <= mode_staged_q; // R21
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_load_q <= 1'b1;
    end else begin
      mode_load_q <= 1'b0;
    end
  end
  // ----------------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------------
  logic [31:0] status_w;
  logic [1:0] gear_idx;
  logic pending_w;
  assign arready = !rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= gear_mode_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= gear_mode_pkg::RESP_OKAY;
      unique case (araddr)
        gear_mode_pkg::ADDR_NUM_PRIMARY: rdata <= 32'(num_q[0]);
        gear_mode_pkg::ADDR_NUM_TWO: rdata <= 32'(num_q[1]);
        gear_mode_pkg::ADDR_NUM_THREE: rdata <= 32'(num_q[2]);
        gear_mode_pkg::ADDR_NUM_FOUR: rdata <= 32'(num_q[3]);
        gear_mode_pkg::ADDR_DENOM: rdata <= 32'(den_q);
        gear_mode_pkg::ADDR_MODE_SET: rdata <= {16'h0000, mode_staged_q};
        gear_mode_pkg::ADDR_TUNE_MODE: rdata <= {16'h0000, tune_mode_q};
        gear_mode_pkg::ADDR_TUNE_LEVEL: rdata <= {26'h0, tune_level_q};
        gear_mode_pkg::ADDR_STATUS: rdata <= status_w;
        gear_mode_pkg::ADDR_TARGET: rdata <= target_pos;
        default: begin
          rdata <= 32'h00000000;
          rresp <= gear_mode_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
  // ----------------------------------------------------------------------
  // Mode switching
  // ----------------------------------------------------------------------
  logic [1:0] want_loop;
  logic want_internal;
  logic sel_on;
  assign sel_on = pin_q[2];
  // Decode which loop the mode input asks for in the live hybrid mode
  always_comb begin
    want_loop = gear_mode_pkg::LOOP_POS;
    want_internal = 1'b0;
    unique case (mode_live_q)
      gear_mode_pkg::MODE_PT_S: // R07 R09
        want_loop = sel_on ? gear_mode_pkg::LOOP_SPEED : gear_mode_pkg::LOOP_POS;
      gear_mode_pkg::MODE_PR_S: begin // R07 R09
        want_loop = sel_on ? gear_mode_pkg::LOOP_SPEED : gear_mode_pkg::LOOP_POS;
        want_internal = 1'b1;
      end
      gear_mode_pkg::MODE_PT_T: // R07 R10
        want_loop = sel_on ? gear_mode_pkg::LOOP_POS : gear_mode_pkg::LOOP_TORQUE;
      gear_mode_pkg::MODE_PR_T: begin // R08 R10
        want_loop = sel_on ? gear_mode_pkg::LOOP_POS : gear_mode_pkg::LOOP_TORQUE;
        want_internal = 1'b1;
      end
      gear_mode_pkg::MODE_S_T: // R08 R10
        want_loop = sel_on ? gear_mode_pkg::LOOP_TORQUE : gear_mode_pkg::LOOP_SPEED;
      gear_mode_pkg::MODE_PT_PR: want_internal = sel_on; // R08 R09
      default: ;
    endcase
  end
  // Changes that touch position wait for zero speed; speed/torque does not
  assign pending_w = (want_loop != active_loop) ||
                     (want_internal != internal_source);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_loop <= gear_mode_pkg::LOOP_POS;
      internal_source <= 1'b0;
    end else if (pending_w && (zero_speed ||
                 (mode_live_q == gear_mode_pkg::MODE_S_T))) begin // R12 R13
      active_loop <= want_loop; // R16
      internal_source <= want_internal;
    end
  end
  // Shared pin feeds whichever function the active loop owns
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      forward_start_input <= 1'b0;
      reverse_select_input <= 1'b0;
    end else begin
      forward_start_input <= pin_q[3] &&
        (active_loop == gear_mode_pkg::LOOP_SPEED); // R15 R16 R17
      reverse_select_input <= pin_q[3] &&
        (active_loop == gear_mode_pkg::LOOP_TORQUE); // R15 R16 R17
    end
  end
  // ----------------------------------------------------------------------
  // Electronic gear
  // ----------------------------------------------------------------------
  logic [GEAR_W-1:0] num_sel, rem_q;
  logic [GEAR_W:0] acc_w;
  logic pulse_d_q;
  logic [31:0] step_q;
  logic busy_q;
  assign gear_idx = pin_q[1:0];
  assign num_sel = num_q[gear_idx]; // R01
  assign status_w = {25'h0, (mode_staged_q != mode_live_q), pending_w,
                     gear_idx, internal_source, active_loop};
  // One count emitted per cycle while the remainder holds a whole count;
  // at most numerator/denominator counts rounded up, so pulses must be spaced out
  assign acc_w = {1'b0, rem_q} + {1'b0, num_sel};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_d_q <= 1'b0;
      rem_q <= '0;
      step_q <= 32'h0;
      busy_q <= 1'b0;
      target_step <= 1'b0;
      target_pos <= 32'h0;
    end else begin
      pulse_d_q <= cmd_pulse;
      target_step <= 1'b0;
      if (cmd_pulse && !pulse_d_q &&
          active_loop == gear_mode_pkg::LOOP_POS && !internal_source) begin
        rem_q <= acc_w[GEAR_W-1:0]; // R06
        busy_q <= 1'b1;
      end else if (busy_q) begin
        if (rem_q >= den_q) begin
          rem_q <= rem_q - den_q; // R06
          target_step <= 1'b1;
          target_pos <= cmd_dir ? target_pos - 32'h1 : target_pos + 32'h1;
        end else begin
          busy_q <= 1'b0;
        end
      end
    end
  end
  // Encoder resolution fixes counts per revolution for the numerator scale
  logic [31:0] unused_ppr;
  assign unused_ppr = gear_mode_pkg::ENCODER_PPR; // R05
  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_pos_switch_gated: assert property (@(posedge aclk) disable iff (!aresetn)
    ($changed(active_loop) && mode_live_q != gear_mode_pkg::MODE_S_T)
    |-> $past(zero_speed)) // R12
    else $error("Loop changed without zero speed");
  a_tp_switch_gated: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(internal_source) |-> $past(zero_speed)) // R13
    else $error("Source changed without zero speed");
  a_fwd_only_speed: assert property (@(posedge aclk) disable iff (!aresetn)
    forward_start_input |-> !reverse_select_input) // R15
    else $error("Shared input drove both functions");
  a_tune_range: assert property (@(posedge aclk) disable iff (!aresetn)
    tune_mode_q <= gear_mode_pkg::TUNE_MODE_MAX) // R19
    else $error("Tuning mode out of range");
  a_level_range: assert property (@(posedge aclk) disable iff (!aresetn)
    tune_level_q >= gear_mode_pkg::TUNE_LEVEL_MIN &&
    tune_level_q <= gear_mode_pkg::TUNE_LEVEL_MAX) // R20
    else $error("Response level out of range");
  a_mode_frozen: assert property (@(posedge aclk) disable iff (!aresetn)
    !$past(mode_load_q) |-> $stable(mode_live_q)) // R21
    else $error("Live mode changed without restart");
  a_den_nonzero: assert property (@(posedge aclk) disable iff (!aresetn)
    den_q != '0 && den_q <= GEAR_W'(gear_mode_pkg::GEAR_MAX)) // R03
    else $error("Denominator out of range");
  a_step_moves: assert property (@(posedge aclk) disable iff (!aresetn)
    target_step |-> target_pos != $past(target_pos)) // R06
    else $error("Step without target change");
endmodule : gear_ratio_and_mode_switch

//--- pulse_source.sv
// Behavioural motion controller that issues position command pulse trains.
// Assumes the bench starts a train only while the gear settings are stable.
`timescale 1ns/1ps
module pulse_source (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic go,
  input wire logic [7:0] count,
  input wire logic dir,
  output logic cmd_pulse,
  output logic cmd_dir,
  output logic busy
);
  logic [7:0] left_q;
  logic [2:0] phase_q;
  // ----------------------------------------------------------------------
  // Pulse train: four cycles high, four low, direction held per train
  // ----------------------------------------------------------------------
  // Wide spacing leaves the ratio logic time to drain each remainder
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      left_q <= 8'h00;
      phase_q <= 3'h0;
      cmd_pulse <= 1'b0;
      cmd_dir <= 1'b0;
      busy <= 1'b0;
    end else if (go && !busy) begin
      left_q <= count;
      phase_q <= 3'h0;
      cmd_dir <= dir;
      busy <= (count != 8'h00);
    end else if (busy) begin
      cmd_pulse <= (phase_q < 3'h4);
      phase_q <= phase_q + 3'h1;
      if (phase_q == 3'h7) begin
        left_q <= left_q - 8'h01;
        busy <= (left_q != 8'h01);
      end
    end else begin
      cmd_pulse <= 1'b0;
    end
  end
endmodule : pulse_source

//--- testbench.sv
// Self-checking bench for the gear ratio and control mode switch block.
// Assumes the AXI4-Lite slave and pulse source share the 20 MHz clock.
`timescale 1ns/1ps
module testbench;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, target_pos, exp_pos, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, active_loop, resp;
  logic awready, wready, bvalid, arready, rvalid, target_step;
  logic gear_select_low, gear_select_high, mode_switch_input;
  logic shared_start_pin, zero_speed, cmd_pulse, cmd_dir;
  logic internal_source, forward_start_input, reverse_select_input;
  logic pgo, pdir, pbusy;
  logic [7:0] pcount;
  int err_total, check_count, step_cnt, s0;
  logic [7:0] rv_addr [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14,
    8'h18, 8'h1c};
  logic [31:0] rv_val [8] = '{32'h1, 32'h1, 32'h1, 32'h1, 32'h1, 32'h0,
    32'h2, 32'ha};
  // Range table: address, value, expected response, expected readback
  logic [7:0] rg_addr [8] = '{8'h18, 8'h18, 8'h1c, 8'h1c, 8'h1c, 8'h04,
    8'h04, 8'h10};
  logic [31:0] rg_val [8] = '{32'h5, 32'h4, 32'h0, 32'h21, 32'h20,
    32'h4000001, 32'h4000000, 32'h0};
  logic [1:0] rg_resp [8] = '{2'h2, 2'h0, 2'h2, 2'h2, 2'h0, 2'h2, 2'h0, 2'h2};
  logic [31:0] rg_rb [8] = '{32'h2, 32'h4, 32'h0a, 32'h0a, 32'h20, 32'h1,
    32'h4000000, 32'h1};
  logic [31:0] nums [4] = '{32'h3, 32'h5, 32'h6, 32'h7};
  logic [15:0] modes [6] = '{16'h1001, 16'h1005, 16'h1011, 16'h1015,
    16'h1003, 16'h1020};
  // Wanted {internal, loop} per code with the switch input off and on
  logic [2:0] ev_off [6] = '{3'h0, 3'h2, 3'h4, 3'h6, 3'h1, 3'h0};
  logic [2:0] ev_on [6] = '{3'h1, 3'h0, 3'h5, 3'h4, 3'h2, 3'h4};
  logic [2:0] ex;

  gear_ratio_and_mode_switch gear_ratio_and_mode_switch_inst (.*);
  pulse_source pulse_source_inst (.aclk(aclk), .aresetn(aresetn), .go(pgo),
    .count(pcount), .dir(pdir), .cmd_pulse(cmd_pulse), .cmd_dir(cmd_dir),
    .busy(pbusy));

  // ----------------------------------------------------------------------
  // Clock, step counter and reporting
  // ----------------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // Counts motor steps independently of target_pos
  always_ff @(posedge aclk) begin
    if (!aresetn) step_cnt <= 0;
    else if (target_step) step_cnt <= step_cnt + 1;
  end
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  task automatic compare_val(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : compare_val
  task automatic timed_out;
    err_total++;
    $display("Error at %0t: wait bound used up", $time);
    complete_run();
  endtask : timed_out
  // ----------------------------------------------------------------------
  // Bus tasks: sample at the falling edge, act at the rising edge
  // ----------------------------------------------------------------------
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           output logic [1:0] r);
    int n;
    logic haw, hw, hb;
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(negedge aclk);
      haw = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid && bready;
      r = bresp;
      @(posedge aclk);
      if (haw) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) begin
        bready <= 1'b0;
        break;
      end
    end
    if (n == 100) timed_out();
  endtask : axi_write
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    int n;
    logic har, hr;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(negedge aclk);
      har = arvalid && arready;
      hr = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (har) arvalid <= 1'b0;
      if (hr) begin
        rready <= 1'b0;
        break;
      end
    end
    if (n == 100) timed_out();
  endtask : axi_read
  // Runs one pulse train through the partner and waits for it to finish
  task automatic send_pulses(input logic [7:0] n, input logic d);
    int k;
    @(posedge aclk);
    pgo <= 1'b1; pcount <= n; pdir <= d;
    @(posedge aclk);
    pgo <= 1'b0;
    for (k = 0; k < 200; k++) begin
      @(negedge aclk);
      if (!pbusy) break;
    end
    if (k == 200) timed_out();
    for (k = 0; k < 40 && target_pos !== exp_pos; k++) @(negedge aclk);
  endtask : send_pulses
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    err_total = 0; check_count = 0; exp_pos = 32'h0;
    aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; awaddr = 8'h00; araddr = 8'h00;
    wdata = 32'h0; wstrb = 4'hf; pgo = 1'b0; pdir = 1'b0; pcount = 8'h00;
    gear_select_low = 1'b0; gear_select_high = 1'b0; zero_speed = 1'b0;
    mode_switch_input = 1'b0; shared_start_pin = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values of every writable setting
    for (int i = 0; i < 8; i++) begin
      axi_read(rv_addr[i], rd, resp);
      compare_val(rd, rv_val[i]);
    end
    // Boundary values accepted, out-of-range values refused untouched
    for (int i = 0; i < 8; i++) begin
      axi_write(rg_addr[i], rg_val[i], resp);
      compare_val({30'h0, resp}, {30'h0, rg_resp[i]});
      axi_read(rg_addr[i], rd, resp);
      compare_val(rd, rg_rb[i]);
    end
    // Unmapped address answers with an error and zero data
    axi_write(8'h28, 32'h1, resp);
    compare_val({30'h0, resp}, {30'h0, gear_mode_pkg::RESP_SLVERR});
    axi_read(8'h28, rd, resp);
    compare_val({rd[29:0], resp}, {30'h0, gear_mode_pkg::RESP_SLVERR});
    // Ratio 3..7 over 4 leaves remainders that must be carried
    axi_write(gear_mode_pkg::ADDR_DENOM, 32'h4, resp);
    for (int i = 0; i < 4; i++) axi_write(rv_addr[i], nums[i], resp);
    for (int i = 0; i < 4; i++) begin
      gear_select_low <= i[0];
      gear_select_high <= i[1];
      repeat (8) @(posedge aclk);
      axi_read(gear_mode_pkg::ADDR_STATUS, rd, resp);
      compare_val({30'h0, rd[4:3]}, {30'h0, i[1:0]});
      s0 = step_cnt;
      exp_pos = (i == 3) ? exp_pos - nums[i] : exp_pos + nums[i];
      send_pulses(8'h04, i == 3);
      compare_val(target_pos, exp_pos);
      compare_val(32'(step_cnt - s0), nums[i]);
      axi_read(gear_mode_pkg::ADDR_TARGET, rd, resp);
      compare_val(rd, exp_pos);
    end
    // Every hybrid code is staged but the live mode waits for a restart
    for (int i = 0; i < 6; i++) begin
      axi_write(gear_mode_pkg::ADDR_MODE_SET, {16'h0, modes[i]}, resp);
      compare_val({30'h0, resp}, 32'h0);
      axi_read(gear_mode_pkg::ADDR_MODE_SET, rd, resp);
      compare_val(rd, {16'h0, modes[i]});
    end
    zero_speed <= 1'b1;
    mode_switch_input <= 1'b1;
    shared_start_pin <= 1'b1;
    repeat (10) @(posedge aclk);
    axi_read(gear_mode_pkg::ADDR_STATUS, rd, resp);
    compare_val({29'h0, rd[6], rd[1:0]}, 32'h4);
    compare_val({29'h0, internal_source, active_loop}, 32'h0);
    // Second reset in mid-run clears position; the staged mode is kept
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(gear_mode_pkg::ADDR_MODE_SET, rd, resp);
    compare_val(rd, {16'h0, gear_mode_pkg::MODE_PT_PR});
    compare_val(target_pos, 32'h0);
    // Each hybrid code goes live at a restart; walk zero speed and switch
    for (int i = 0; i < 6; i++) begin
      axi_write(gear_mode_pkg::ADDR_MODE_SET, {16'h0, modes[i]}, resp);
      zero_speed <= 1'b0;
      mode_switch_input <= 1'b0;
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      for (int j = 0; j < 4; j++) begin
        @(posedge aclk);
        zero_speed <= j[0];
        mode_switch_input <= j[1];
        repeat (10) @(posedge aclk);
        @(negedge aclk);
        // Without zero speed only speed/torque may move
        if (j[0] || i == 4) ex = j[1] ? ev_on[i] : ev_off[i];
        else ex = j[1] ? ev_off[i] : 3'h0;
        compare_val(32'({internal_source, active_loop}), 32'(ex));
        compare_val(32'({forward_start_input, reverse_select_input}),
                    32'({ex[1:0] == 2'h1, ex[1:0] == 2'h2}));
      end
    end
    complete_run();
  end
endmodule : testbench
